// ==== verification/ihr_conv_src.sv ====
// Behavioural conversion engine that feeds channel samples into the readout.
`timescale 1ns/1ps
module ihr_conv_src (
  input wire logic clk_i,
  output logic conv_valid_o,
  output logic [1:0] conv_chan_o,
  output logic [15:0] conv_counts_o,
  output logic [15:0] conv_lta_o
);
  // Idle at time zero, with a pattern on the data lines rather than a plausible sample.
  initial begin
    conv_valid_o = 1'b0;
    conv_chan_o = 2'h0;
    conv_counts_o = 16'h5a5a;
    conv_lta_o = 16'ha5a5;
  end

  // One-cycle pulse after an optional delay; afterwards the data lines invert, so stale data never looks held.
  task automatic send(input logic [1:0] ch, input logic [15:0] cnt, input logic [15:0] long_term_average, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    conv_valid_o <= 1'b1;
    conv_chan_o <= ch;
    conv_counts_o <= cnt;
    conv_lta_o <= long_term_average;
    @(posedge clk_i);
    conv_valid_o <= 1'b0;
    conv_chan_o <= ~ch;
    conv_counts_o <= ~cnt;
    conv_lta_o <= ~long_term_average;
  endtask
endmodule

// ==== verification/ihr_readout_tb_top.sv ====
// Self-checking bench for the hysteresis readout: APB registers, channel-2 conversions, events and interrupt.
`timescale 1ns/1ps
`include "ihr_cfg.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; $display("Error %s expected %h seen %h", nm, ex, gt); end end
module ihr_readout_tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, q;
  logic pready, pslverr, cv, nr, ct, irq, e;
  logic [1:0] cch;
  logic [15:0] ccnt, clta;
  logic [2:0] disc = 3'h0;
  logic [1:0] cind = 2'h0;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] rw [10] = '{`IHR_IDX_MODE, `IHR_IDX_INDCFG, `IHR_IDX_TUNE, `IHR_IDX_EXTRA, `IHR_IDX_UIEN,
    `IHR_IDX_HYST, `IHR_IDX_HALT, `IHR_IDX_NEAR, `IHR_IDX_CONTACT, `IHR_IDX_IRQ_MASK};
  logic [7:0] ro [4] = '{`IHR_IDX_GLOBAL, `IHR_IDX_FLAGS, `IHR_IDX_MAG_LO, `IHR_IDX_MAG_HI};
  // Samples around the thresholds 20 and 40 with hysteresis 4 and 5; tf holds {contact, near}.
  logic [15:0] tc [9] = '{16'd1025, 16'd1017, 16'd985, 16'd1017, 16'd1045, 16'd964, 16'd1034, 16'd1020, 16'd1010};
  logic [1:0] tf [9] = '{2'b01, 2'b01, 2'b00, 2'b00, 2'b11, 2'b11, 2'b01, 2'b01, 2'b00};

  ihr_readout DUT (.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .conv_valid_i(cv), .conv_chan_i(cch), .conv_counts_i(ccnt), .conv_lta_i(clta),
    .discrete_detect_event_i(disc), .chan_inductive_i(cind), .near_o(nr), .contact_o(ct), .irq_o(irq));
  ihr_conv_src SRC (.clk_i(clk_i), .conv_valid_o(cv), .conv_chan_o(cch), .conv_counts_o(ccnt), .conv_lta_o(clta));

  // Free-running 50 MHz clock.
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("data at %h", a), {24'h0, x}, q)
    `CHK($sformatf("error at %h", a), xe, e)
  endtask

  // A conversion is published two edges after it is accepted; the task waits three.
  task automatic conv(input logic [1:0] ch, input logic [15:0] cnt);
    SRC.send(ch, cnt, 16'd1000, 1);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // Discrete detection levels feed global bit 0 after a short settling time.
  task automatic ev(input logic [1:0] ind, input logic [2:0] d, input logic [7:0] x);
    cind <= ind;
    disc <= d;
    repeat (3) @(posedge clk_i);
    rd(ba(`IHR_IDX_GLOBAL), x, 1'b0);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few hundred cycles, this allows ten thousand.
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // Main sequence.
  initial begin
    logic [15:0] m;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rw[i]) rd(ba(rw[i]), 8'h00, 1'b0);
    foreach (ro[i]) rd(ba(ro[i]), 8'h00, 1'b0);
    foreach (rw[i]) wr(ba(rw[i]), rw[i] ^ 8'h5a);
    foreach (rw[i]) rd(ba(rw[i]), rw[i] ^ 8'h5a, 1'b0);
    wr(ba(`IHR_IDX_FLAGS), 8'hff);
    rd(ba(`IHR_IDX_FLAGS), 8'h00, 1'b0);
    pstrb <= 4'h0;
    wr(ba(`IHR_IDX_HALT), 8'h77);
    pstrb <= 4'hf;
    rd(ba(`IHR_IDX_HALT), `IHR_IDX_HALT ^ 8'h5a, 1'b0);
    rd(ba(8'h20), 8'h00, 1'b1);
    rd(ba(`IHR_IDX_HYST) | 10'h001, 8'h00, 1'b1);
    $display("test registers done");
    // Only the inductive, hysteresis and interrupt-mask registers are programmed, none of the absorption ones.
    wr(ba(`IHR_IDX_MODE), 8'h02);
    wr(ba(`IHR_IDX_INDCFG), 8'h03);
    wr(ba(`IHR_IDX_TUNE), 8'h21);
    wr(ba(`IHR_IDX_HYST), 8'h54);
    wr(ba(`IHR_IDX_HALT), 8'hff);
    wr(ba(`IHR_IDX_NEAR), 8'd20);
    wr(ba(`IHR_IDX_CONTACT), 8'd40);
    wr(ba(`IHR_IDX_IRQ_MASK), 8'h08);
    wr(ba(`IHR_IDX_UIEN), 8'h01);
    foreach (tc[i]) begin
      conv(2'h2, tc[i]);
      m = (tc[i] > 16'd1000) ? tc[i] - 16'd1000 : 16'd1000 - tc[i];
      `CHK("near_o", tf[i][0], nr)
      `CHK("contact_o", tf[i][1], ct)
      rd(ba(`IHR_IDX_FLAGS), {tc[i] > 16'd1000, tf[i][1], tf[i][0], 5'h00}, 1'b0);
      rd(ba(`IHR_IDX_MAG_LO), m[7:0], 1'b0);
      rd(ba(`IHR_IDX_MAG_HI), m[15:8], 1'b0);
      rd(ba(`IHR_IDX_GLOBAL), {4'h0, |tf[i], 3'h0}, 1'b0);
      `CHK("irq_o", 1'b1, irq)
    end
    $display("test conversions done");
    // The halt only freezes a running filter, so the filter is switched on first.
    wr(ba(`IHR_IDX_HALT), 8'd30);
    wr(ba(`IHR_IDX_UIEN), 8'h03);
    conv(2'h2, 16'd1050);
    rd(ba(`IHR_IDX_MAG_LO), 8'd10, 1'b0);
    wr(ba(`IHR_IDX_HALT), 8'hff);
    conv(2'h2, 16'd1030);
    rd(ba(`IHR_IDX_MAG_LO), 8'd20, 1'b0);
    `CHK("near_o", 1'b1, nr)
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        conv(2'(c), 16'd1200);
        rd(ba(`IHR_IDX_MAG_LO), 8'd20, 1'b0);
      end
    end
    $display("test filter and channel done");
    ev(2'b01, 3'b001, 8'h09);
    ev(2'b00, 3'b010, 8'h08);
    ev(2'b00, 3'b100, 8'h09);
    ev(2'b00, 3'b000, 8'h08);
    ev(2'b10, 3'b010, 8'h09);
    wr(ba(`IHR_IDX_MODE), 8'h01);
    ev(2'b00, 3'b100, 8'h08);
    ev(2'b00, 3'b000, 8'h08);
    rd(ba(`IHR_IDX_IRQ_STAT), 8'h09, 1'b0);
    wr(ba(`IHR_IDX_IRQ_MASK), 8'h00);
    rd(ba(`IHR_IDX_IRQ_STAT), 8'h09, 1'b0);
    `CHK("irq_o", 1'b0, irq)
    wr(ba(`IHR_IDX_IRQ_MASK), 8'h01);
    rd(ba(`IHR_IDX_IRQ_MASK), 8'h01, 1'b0);
    `CHK("irq_o", 1'b1, irq)
    wr(ba(`IHR_IDX_IRQ_STAT), 8'h09);
    rd(ba(`IHR_IDX_IRQ_STAT), 8'h00, 1'b0);
    `CHK("irq_o", 1'b0, irq)
    wr(ba(`IHR_IDX_UIEN), 8'h00);
    conv(2'h2, 16'd1045);
    `CHK("near_o", 1'b0, nr)
    `CHK("contact_o", 1'b0, ct)
    rd(ba(`IHR_IDX_MAG_LO), 8'd45, 1'b0);
    rd(ba(`IHR_IDX_GLOBAL), 8'h00, 1'b0);
    rd(ba(`IHR_IDX_IRQ_STAT), 8'h00, 1'b0);
    // A conversion between the two byte reads must not tear the 16-bit value.
    conv(2'h2, 16'd1300);
    rd(ba(`IHR_IDX_MAG_LO), 8'h2c, 1'b0);
    conv(2'h2, 16'd1000);
    rd(ba(`IHR_IDX_MAG_HI), 8'h01, 1'b0);
    rd(ba(`IHR_IDX_MAG_LO), 8'h00, 1'b0);
    rd(ba(`IHR_IDX_MAG_HI), 8'h00, 1'b0);
    $display("test events and interrupt done");
    results();
  end
endmodule

// ==== verilog/ihr_cfg.svh ====
// Register indices, field positions, reset values and fixed figures of the hysteresis readout.
`ifndef IHR_CFG_SVH
`define IHR_CFG_SVH
// Register indices; the byte address is four times the index.
`define IHR_IDX_GLOBAL 8'h11
`define IHR_IDX_FLAGS 8'h13
`define IHR_IDX_MAG_LO 8'h14
`define IHR_IDX_MAG_HI 8'h15
`define IHR_IDX_MODE 8'h42
`define IHR_IDX_INDCFG 8'h45
`define IHR_IDX_TUNE 8'h48
`define IHR_IDX_EXTRA 8'h4b
`define IHR_IDX_UIEN 8'h50
`define IHR_IDX_HYST 8'h80
`define IHR_IDX_HALT 8'h81
`define IHR_IDX_NEAR 8'h82
`define IHR_IDX_CONTACT 8'h83
`define IHR_IDX_IRQ_STAT 8'he0
`define IHR_IDX_IRQ_MASK 8'he1
// Address split: word index above the two byte-lane bits.
`define IHR_IDX_LSB 2
`define IHR_IDX_W 8
// Field positions.
`define IHR_EN_BIT 0
`define IHR_FILT_BIT 1
`define IHR_HP_LSB 0
`define IHR_HT_LSB 4
`define IHR_HYST_W 4
`define IHR_MODE_LSB 0
`define IHR_MODE_W 2
`define IHR_MODE_IND 2'h2
`define IHR_F_SIGN 7
`define IHR_F_TOUCH 6
`define IHR_F_PROX 5
`define IHR_G_DISC 0
`define IHR_G_HYST 3
// The one sensing channel that may feed the hysteresis interface.
`define IHR_HYST_CHAN 2'h2
// Reset values.
`define IHR_RST_CFG 8'h00
`define IHR_RST_MAG 16'h0000
`endif

// ==== verilog/ihr_pkg.sv ====
// Types shared by the hysteresis readout design.
package ihr_pkg;
  typedef enum logic [1:0] {IHR_IDLE, IHR_CALC, IHR_COMMIT} ihr_state_e;
  typedef logic [7:0] ihr_byte_t;
endpackage

// ==== verilog/ihr_readout.sv ====
// Hysteresis readout for inductive channel 2: APB registers, thresholds, flags, magnitude, interrupt.
//
// How it works
// - Only channel 2 feeds the hysteresis interface.
// - Hysteresis runs alongside discrete or absorption interfaces.
// - Global bit 0: discrete detection, inductive channels.
// - Global bit 3: hysteresis detection while enabled.
// - Flag register: sign, touch, proximity, rest zero.
// - Magnitude: 16 bits, low byte first.
// - Filter halts when halt threshold is crossed.
// - Proximity from channel-2 data versus threshold.
// - Touch from channel-2 data versus threshold.
// - Hysteresis amounts apply to proximity and touch.
// - Enable and filter come from enable register.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "ihr_cfg.svh"
module ihr_readout
  import ihr_pkg::*;
#(
  parameter int AW = 10,
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic conv_valid_i,
  input wire logic [1:0] conv_chan_i,
  input wire logic [CW-1:0] conv_counts_i,
  input wire logic [CW-1:0] conv_lta_i,
  input wire logic [2:0] discrete_detect_event_i,
  input wire logic [1:0] chan_inductive_i,
  output logic near_o,
  output logic contact_o,
  output logic irq_o
);

  // The index field must fit the address and the counts must fit the 16-bit magnitude.
  if (AW < `IHR_IDX_W + `IHR_IDX_LSB) begin : g_aw_chk
    $error("AW too small for the register map");
  end
  if (CW < 8 || CW > 16) begin : g_cw_chk
    $error("CW must lie between 8 and 16");
  end

  // Decoding shared by the read path, the write path and the snapshot.
  function automatic ihr_byte_t reg_idx(input logic [AW-1:0] a);
    reg_idx = a[`IHR_IDX_LSB +: `IHR_IDX_W];
  endfunction

  function automatic logic reg_hit(input logic [AW-1:0] a);
    logic ok;
    ok = (a[`IHR_IDX_LSB-1:0] == '0) && (a >> (`IHR_IDX_W + `IHR_IDX_LSB)) == '0;
    unique case (reg_idx(a))
      `IHR_IDX_GLOBAL, `IHR_IDX_FLAGS, `IHR_IDX_MAG_LO, `IHR_IDX_MAG_HI,
      `IHR_IDX_MODE, `IHR_IDX_INDCFG, `IHR_IDX_TUNE, `IHR_IDX_EXTRA,
      `IHR_IDX_UIEN, `IHR_IDX_HYST, `IHR_IDX_HALT, `IHR_IDX_NEAR,
      `IHR_IDX_CONTACT, `IHR_IDX_IRQ_STAT, `IHR_IDX_IRQ_MASK: reg_hit = ok;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // A flag is set at or above the threshold and released only once the data drops below
  // the threshold by more than the hysteresis amount, so a noisy edge does not chatter.
  function automatic logic hyst_level(input logic cur, input logic [15:0] val, input ihr_byte_t thr,
                                      input logic [`IHR_HYST_W-1:0] h);
    logic [16:0] lifted;
    lifted = {1'b0, val} + {13'h0000, h};
    if ({1'b0, val} >= {9'h000, thr}) begin
      hyst_level = 1'b1;
    end else begin
      hyst_level = cur && (lifted >= {9'h000, thr});
    end
  endfunction

  ihr_state_e state_r;
  ihr_byte_t mode_r, indcfg_r, tune_r, extra_r, uien_r, hyst_r, halt_r, near_thr_r, contact_thr_r;
  ihr_byte_t irq_stat_r, irq_mask_r, global_r, global_nxt, flags_r, hi_shadow_r, rd_byte;
  logic [CW-1:0] cnt_r, lta_r;
  logic [15:0] mag_r, filt_r, filt_nxt, raw_mag;
  logic above_r, above_nxt, near_r, contact_r, hold_hi_r, halt_now;
  logic pready_r, pslverr_r, irq_r, setup, access_rd, wr_go, accept, hyst_en, filt_en;
  logic [16:0] filt_sum;
  logic [31:0] prdata_r;

  assign hyst_en = uien_r[`IHR_EN_BIT];
  assign filt_en = uien_r[`IHR_FILT_BIT];
  assign setup = psel_i & ~penable_i;
  assign access_rd = psel_i & penable_i & pready_r & ~pwrite_i;
  assign wr_go = psel_i & penable_i & pready_r & pwrite_i & pstrb_i[0] & reg_hit(paddr_i);
  // Samples from any other channel are dropped here and never reach the thresholds.
  assign accept = conv_valid_i && (conv_chan_i == `IHR_HYST_CHAN) && (state_r == IHR_IDLE);

  // Read mux; reserved bits and unmapped indices read as zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_idx(paddr_i))
      `IHR_IDX_GLOBAL: rd_byte = global_r;
      `IHR_IDX_FLAGS: rd_byte = flags_r;
      `IHR_IDX_MAG_LO: rd_byte = mag_r[7:0];
      `IHR_IDX_MAG_HI: rd_byte = hold_hi_r ? hi_shadow_r : mag_r[15:8];
      `IHR_IDX_MODE: rd_byte = mode_r;
      `IHR_IDX_INDCFG: rd_byte = indcfg_r;
      `IHR_IDX_TUNE: rd_byte = tune_r;
      `IHR_IDX_EXTRA: rd_byte = extra_r;
      `IHR_IDX_UIEN: rd_byte = uien_r;
      `IHR_IDX_HYST: rd_byte = hyst_r;
      `IHR_IDX_HALT: rd_byte = halt_r;
      `IHR_IDX_NEAR: rd_byte = near_thr_r;
      `IHR_IDX_CONTACT: rd_byte = contact_thr_r;
      `IHR_IDX_IRQ_STAT: rd_byte = irq_stat_r;
      `IHR_IDX_IRQ_MASK: rd_byte = irq_mask_r;
      default: rd_byte = 8'h00;
    endcase
    if (!reg_hit(paddr_i)) begin
      rd_byte = 8'h00;
    end
  end

  // The answer is prepared in the setup cycle, so every transfer finishes in its first access cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= ~reg_hit(paddr_i);
        prdata_r <= {24'h00_0000, rd_byte};
      end else if (!psel_i) begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Configuration registers; read-only indices ignore writes.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= `IHR_RST_CFG;
      indcfg_r <= `IHR_RST_CFG;
      tune_r <= `IHR_RST_CFG;
      extra_r <= `IHR_RST_CFG;
      uien_r <= `IHR_RST_CFG;
      hyst_r <= `IHR_RST_CFG;
      halt_r <= `IHR_RST_CFG;
      near_thr_r <= `IHR_RST_CFG;
      contact_thr_r <= `IHR_RST_CFG;
      irq_mask_r <= `IHR_RST_CFG;
    end else if (wr_go) begin
      unique case (reg_idx(paddr_i))
        `IHR_IDX_MODE: mode_r <= pwdata_i[7:0];
        `IHR_IDX_INDCFG: indcfg_r <= pwdata_i[7:0];
        `IHR_IDX_TUNE: tune_r <= pwdata_i[7:0];
        `IHR_IDX_EXTRA: extra_r <= pwdata_i[7:0];
        `IHR_IDX_UIEN: uien_r <= pwdata_i[7:0];
        `IHR_IDX_HYST: hyst_r <= pwdata_i[7:0];
        `IHR_IDX_HALT: halt_r <= pwdata_i[7:0];
        `IHR_IDX_NEAR: near_thr_r <= pwdata_i[7:0];
        `IHR_IDX_CONTACT: contact_thr_r <= pwdata_i[7:0];
        `IHR_IDX_IRQ_MASK: irq_mask_r <= pwdata_i[7:0];
        default: mode_r <= mode_r;
      endcase
    end
  end

  // High-byte snapshot: reading the low byte freezes the high byte until it is read, so a
  // conversion landing between the two byte reads cannot tear the 16-bit value.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_hi_r <= 1'b0;
      hi_shadow_r <= 8'h00;
    end else if (setup && !pwrite_i && reg_hit(paddr_i) && reg_idx(paddr_i) == `IHR_IDX_MAG_LO) begin
      hold_hi_r <= 1'b1;
      hi_shadow_r <= mag_r[15:8];
    end else if (access_rd && reg_idx(paddr_i) == `IHR_IDX_MAG_HI) begin
      hold_hi_r <= 1'b0;
    end
  end

  // Magnitude and direction against the long-term average, plus the filter step.
  always_comb begin
    above_nxt = cnt_r > lta_r;
    raw_mag = (cnt_r >= lta_r) ? 16'(cnt_r - lta_r) : 16'(lta_r - cnt_r);
    halt_now = raw_mag > {8'h00, halt_r};
    filt_sum = {1'b0, filt_r} + {1'b0, raw_mag};
    if (!filt_en) begin
      filt_nxt = raw_mag;
    end else if (halt_now) begin
      filt_nxt = filt_r;
    end else begin
      filt_nxt = filt_sum[16:1];
    end
  end

  // Conversion pipeline: latch a channel-2 sample, filter it, then publish all results at once.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= IHR_IDLE;
      cnt_r <= '0;
      lta_r <= '0;
      filt_r <= `IHR_RST_MAG;
      above_r <= 1'b0;
    end else begin
      unique case (state_r)
        IHR_IDLE: begin
          if (accept) begin
            cnt_r <= conv_counts_i;
            lta_r <= conv_lta_i;
            state_r <= IHR_CALC;
          end
        end
        IHR_CALC: begin
          filt_r <= filt_nxt;
          above_r <= above_nxt;
          state_r <= IHR_COMMIT;
        end
        IHR_COMMIT: begin
          state_r <= IHR_IDLE;
        end
        // The two-bit state has one unused code; fall back to idle rather than lock up.
        default: begin
          state_r <= IHR_IDLE;
        end
      endcase
    end
  end

  // Flags and magnitude change only in the commit cycle, all in the same edge.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      near_r <= 1'b0;
      contact_r <= 1'b0;
      mag_r <= `IHR_RST_MAG;
      flags_r <= 8'h00;
    end else if (state_r == IHR_COMMIT) begin
      near_r <= hyst_en && hyst_level(near_r, filt_r, near_thr_r,
                                      hyst_r[`IHR_HP_LSB +: `IHR_HYST_W]);
      contact_r <= hyst_en && hyst_level(contact_r, filt_r, contact_thr_r,
                                         hyst_r[`IHR_HT_LSB +: `IHR_HYST_W]);
      mag_r <= filt_r;
      flags_r <= 8'h00;
      flags_r[`IHR_F_SIGN] <= above_r;
      flags_r[`IHR_F_TOUCH] <= hyst_en && hyst_level(contact_r, filt_r, contact_thr_r,
                                                     hyst_r[`IHR_HT_LSB +: `IHR_HYST_W]);
      flags_r[`IHR_F_PROX] <= hyst_en && hyst_level(near_r, filt_r, near_thr_r,
                                                    hyst_r[`IHR_HP_LSB +: `IHR_HYST_W]);
    end
  end

  // Global events: the discrete path runs beside the hysteresis path and neither gates the other.
  always_comb begin
    global_nxt = 8'h00;
    global_nxt[`IHR_G_DISC] = |(discrete_detect_event_i &
                                {mode_r[`IHR_MODE_LSB +: `IHR_MODE_W] == `IHR_MODE_IND,
                                 chan_inductive_i});
    global_nxt[`IHR_G_HYST] = hyst_en && (near_r || contact_r);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      global_r <= 8'h00;
    end else begin
      global_r <= global_nxt;
    end
  end

  // Sticky interrupt status, write one to clear; a new event in the clear cycle still lands.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_r <= 8'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_go && reg_idx(paddr_i) == `IHR_IDX_IRQ_STAT) ? pwdata_i[7:0] : 8'h00))
                    | (global_nxt & ~global_r);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign near_o = near_r;
  assign contact_o = contact_r;
  assign irq_o = irq_r;

  // Checks on the published behaviour.
  a_chan_filter_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_IDLE && conv_valid_i && conv_chan_i != `IHR_HYST_CHAN) |=> state_r == IHR_IDLE)
    else $error("sample from another channel entered the pipeline");
  a_discrete_event_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ##1 global_r[`IHR_G_DISC] == $past(|(discrete_detect_event_i & {mode_r[1:0] == `IHR_MODE_IND,
                                                                     chan_inductive_i})))
    else $error("discrete event bit wrong");
  a_hyst_event_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    global_r[`IHR_G_HYST] |-> $past(hyst_en) && ($past(near_r) || $past(contact_r)))
    else $error("hysteresis event bit without detection");
  a_flags_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
    flags_r[4:0] == 5'h00 && flags_r[`IHR_F_PROX] == near_r && flags_r[`IHR_F_TOUCH] == contact_r)
    else $error("flag register layout broken");
  a_halt_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_CALC && filt_en && halt_now) |=> $stable(filt_r) ##1 mag_r == $past(filt_r, 2))
    else $error("filter moved while halted");
  a_near_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT && hyst_en && filt_r >= {8'h00, near_thr_r}) |=> near_r && near_o)
    else $error("proximity not set at threshold");
  a_contact_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT && hyst_en && filt_r >= {8'h00, contact_thr_r}) |=> contact_r)
    else $error("touch not set at threshold");
  a_near_hold_band: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT && hyst_en && near_r &&
     ({1'b0, filt_r} + {13'h0000, hyst_r[3:0]}) >= {9'h000, near_thr_r}) |=> near_r)
    else $error("proximity released inside the hysteresis band");
  a_disable_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT && !hyst_en) |=> !near_r && !contact_r)
    else $error("flags set while interface disabled");
  a_commit_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($changed(mag_r) || $changed(flags_r)) |-> $past(state_r) == IHR_COMMIT)
    else $error("result changed outside commit");
  a_apb_one_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (psel_i && !penable_i) |=> pready_o)
    else $error("apb answer late");

  // Pipeline, hysteresis, interrupt, bus-error and snapshot checks; a lost event or a torn read would go unseen by software.
  a_idle_accept: assert property (@(posedge clk_i) disable iff (!resetn_i)
    accept |=> state_r == IHR_CALC)
    else $error("channel-2 sample not taken while idle");
  a_contact_hold_band: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT && hyst_en && contact_r &&
     ({1'b0, filt_r} + {13'h0000, hyst_r[`IHR_HT_LSB +: `IHR_HYST_W]}) >= {9'h000, contact_thr_r}) |=> contact_r)
    else $error("touch released inside the hysteresis band");
  a_mag_publish: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == IHR_COMMIT) |=> mag_r == $past(filt_r))
    else $error("magnitude not published at commit");
  a_global_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (global_r & ~((8'h01 << `IHR_G_DISC) | (8'h01 << `IHR_G_HYST))) == 8'h00)
    else $error("unused global event bit set");
  a_stat_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (global_nxt[`IHR_G_HYST] && !global_r[`IHR_G_HYST]) |=> irq_stat_r[`IHR_G_HYST])
    else $error("hysteresis event lost from status");
  a_status_w1c: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_go && reg_idx(paddr_i) == `IHR_IDX_IRQ_STAT && pwdata_i[`IHR_G_HYST] &&
     !(global_nxt[`IHR_G_HYST] && !global_r[`IHR_G_HYST])) |=> !irq_stat_r[`IHR_G_HYST])
    else $error("status bit not cleared by write of one");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (|(irq_stat_r & irq_mask_r)) |=> irq_o)
    else $error("interrupt low with unmasked status");
  a_hi_frozen: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (hold_hi_r && !psel_i) |=> hold_hi_r && $stable(hi_shadow_r))
    else $error("high byte snapshot moved");
  a_slverr_unmapped: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (psel_i && !penable_i && !reg_hit(paddr_i)) |=> pslverr_o && pready_o)
    else $error("unmapped access without bus error");
  a_pready_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pready_o |=> !pready_o)
    else $error("apb ready held too long");
  c_near_rise: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(near_r));
  c_contact_rise: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(contact_r));
  c_halt_hit: cover property (@(posedge clk_i) disable iff (!resetn_i) state_r == IHR_CALC && filt_en && halt_now);
  c_irq_rise: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(irq_o));
  c_hi_snapshot: cover property (@(posedge clk_i) disable iff (!resetn_i) hold_hi_r && state_r == IHR_COMMIT);

endmodule
